//--- shared/sent_slot_pkg.sv
package sent_slot_pkg;
    // Register map
    localparam logic [7:0] CFG_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;
    localparam int ZERO_SAMPLE_BIT = 25;
    localparam int SLOT_SYNC_BIT = 24;
    localparam int SLOT_MARK_BIT = 23;
    localparam int POR_OFFLINE_BIT = 22;
    localparam int IDLE_SYNC_BIT = 21;
    localparam int HOLD_ADDR_BIT = 20;
    localparam int NO_SAMPLE_BIT = 19;
    localparam int MAX_SENS_LSB = 16;
    localparam int MAX_SENS_MSB = 17;
    // Transmit schemes
    localparam logic [2:0] SCHEME_LONG = 3'h3;
    localparam logic [2:0] SCHEME_SHORT = 3'h4;
    localparam logic [2:0] SCHEME_ID = 3'h5;
    // Function pulse windows in ticks
    localparam logic [9:0] SHORT_OUT_MIN = 10'h00F;
    localparam logic [9:0] SHORT_OUT_MAX = 10'h013;
    localparam logic [9:0] SHORT_SMP_MIN = 10'h01F;
    localparam logic [9:0] SHORT_SMP_MAX = 10'h027;
    localparam logic [9:0] SHORT_SYNC_MIN = 10'h05D;
    localparam logic [9:0] SHORT_SYNC_MAX = 10'h073;
    localparam logic [9:0] LONG_OUT_MIN = 10'h009;
    localparam logic [9:0] LONG_OUT_MAX = 10'h051;
    localparam logic [9:0] LONG_SYNC_MIN = 10'h069;
    localparam logic [9:0] LONG_SYNC_MAX = 10'h0AB;
    // High-time figures, counter cap and frame sync pulse length in ticks
    localparam logic [9:0] IDLE_TICKS = 10'h1FE;
    localparam logic [9:0] ID_END_TICKS = 10'h012;
    localparam logic [9:0] MIN_HIGH_TICKS = 10'h007;
    localparam logic [9:0] MARK_LIM0 = 10'h00D;
    localparam logic [9:0] MARK_LIM1 = 10'h01B;
    localparam logic [9:0] MARK_LIM2 = 10'h031;
    localparam logic [9:0] MARK_TIMEOUT = 10'h050;
    localparam logic [9:0] TICK_SAT = 10'h3FF;
    localparam logic [9:0] SYNC_PULSE_TICKS = 10'h038;
    // Least time from function pulse end to frame sync pulse end
    localparam real MIN_RESP_US = 70.4;
    localparam real CLK_MHZ = 125.0;
    localparam logic [19:0] MIN_RESP_CYC = 20'($rtoi($ceil(MIN_RESP_US * CLK_MHZ)));

    function automatic logic [9:0] markTicks(input logic [1:0] id);
        logic [9:0] t;
        unique case (id)
            2'h0: t = 10'h007;
            2'h1: t = 10'h012;
            2'h2: t = 10'h024;
            2'h3: t = 10'h03E;
        endcase
        return t;
    endfunction : markTicks
endpackage : sent_slot_pkg

//--- rtl/sent_slot_addressing.sv
`timescale 1ns/1ps
// Functional notes
// R01: Offline non-contention sensor loads slot counter from first measured slot mark.
// R02: Host issues sync pulse when nobody answers.
// R03: Idle sync clears slot counter after line high above 510 ticks.
// R04: Power-on-offline keeps sensor offline until a sync mechanism acts.
// R05: Without power-on-offline, counter cleared and online right after reset.
// R06: Function identified only by measured low pulse width.
// R07: Response waits at least 7 ticks of high line.
// R08: Response delay stretched to keep 70.4 us before sync pulse end.
// R09: Output request returns held sample if present, else current data.
// R10: Sequential zero-slot sampling holds on slot 0 output request.
// R11: Sequential no-sample without zero-slot never holds.
// R12: Sample pulse addresses a sensor only when hold-addressing is set.
// R13: Sync pulse makes next addressing pulse slot zero.
// R14: Short sequential windows: 15-19 output, 31-39 sample, 93-115 sync.
// R15: Long sequential windows: 9-81 output, 105-171 sync, no sample.
// R16: Host sends zero to three id count pulses after an addressing pulse.
// R17: Id sequence ends after 18 high ticks; respond when count equals id.
// R18: Id scheme windows: 15-19 output, 31-39 sample.
// R19: Id scheme no-sample skips holds and answers current data.
// R20: All sensors on a bus should share sampling options.
// R21: Sequential counter steps on each addressing pulse; respond on match.
// R22: Slot counter wraps to zero past configured sensor count.
// R23: Slot marking delays 7, 18, 36, 62 ticks for ids 0 to 3.
// R24: Slot mark mismatch against own counter drops sensor offline.
// R25: Offline sensor tracks pulses but never starts a frame.
module sent_slot_addressing #(
    parameter logic [15:0] TICK_CYCLES = 16'h007D,
    parameter logic [31:0] CFG_RESET = 32'h0000_0000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Shared line level
    input wire logic lineIn,
    // Static setup
    input wire logic [1:0] sensorId,
    input wire logic [2:0] transmitSchemeSelect,
    // Register port
    input wire logic cfgWe,
    input wire logic [7:0] cfgAddr,
    input wire logic [31:0] cfgWdata,
    output logic [31:0] cfgRdata,
    // Frame transmitter and sampler
    output logic frameStart,
    output logic frameUseHeld,
    output logic sampleHold,
    output logic online
);
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WAIT} state_t;

    state_t state_q, state_d;
    logic lineMeta_q, lineSync_q, linePrev_q;
    logic [15:0] tickDiv_q;
    logic [9:0] lowTicks_q, highTicks_q;
    logic [31:0] cfg_q, cfgRdata_q;
    logic [1:0] slotCnt_q, slotCnt_d, incCnt_q, incCnt_d, expSlot_q, expSlot_d;
    logic online_q, online_d, contention_q, contention_d;
    logic heldValid_q, heldValid_d, pwrUp_q;
    logic measPend_q, measPend_d, skip_q, skip_d;
    logic [19:0] waitCnt_q, waitCnt_d;
    logic frameStart_q, frameStart_d, frameUseHeld_q, frameUseHeld_d;
    logic sampleHold_q, sampleHold_d;

    // Line edges and tick
    wire lineFall = linePrev_q & ~lineSync_q;
    wire lineRise = ~linePrev_q & lineSync_q;
    wire tick = tickDiv_q == TICK_CYCLES - 16'h0001;
    wire idleEvt = tick & lineSync_q & ~lineRise & (highTicks_q == sent_slot_pkg::IDLE_TICKS);
    wire highLong = lineSync_q & (highTicks_q > sent_slot_pkg::MARK_TIMEOUT);

    // Configuration fields
    wire zeroSample = cfg_q[sent_slot_pkg::ZERO_SAMPLE_BIT];
    wire slotSync = cfg_q[sent_slot_pkg::SLOT_SYNC_BIT];
    wire slotMark = cfg_q[sent_slot_pkg::SLOT_MARK_BIT];
    wire porOffline = cfg_q[sent_slot_pkg::POR_OFFLINE_BIT];
    wire idleSync = cfg_q[sent_slot_pkg::IDLE_SYNC_BIT];
    wire holdPulseAddresses = cfg_q[sent_slot_pkg::HOLD_ADDR_BIT];
    wire noSample = cfg_q[sent_slot_pkg::NO_SAMPLE_BIT];
    wire [1:0] maxSens = cfg_q[sent_slot_pkg::MAX_SENS_MSB:sent_slot_pkg::MAX_SENS_LSB];

    wire modeShort = transmitSchemeSelect == sent_slot_pkg::SCHEME_SHORT;
    wire modeLong = transmitSchemeSelect == sent_slot_pkg::SCHEME_LONG;
    wire modeId = transmitSchemeSelect == sent_slot_pkg::SCHEME_ID;
    wire seqMode = modeShort | modeLong;
    wire shortWin = modeShort | modeId;

    // Pulse classification at the rising edge; frame sync pulses are skipped
    wire decodeEn = lineRise & ~skip_q; // R06
    wire inShortOut = lowTicks_q >= sent_slot_pkg::SHORT_OUT_MIN
        && lowTicks_q <= sent_slot_pkg::SHORT_OUT_MAX;
    wire inShortSmp = lowTicks_q >= sent_slot_pkg::SHORT_SMP_MIN
        && lowTicks_q <= sent_slot_pkg::SHORT_SMP_MAX;
    wire inShortSync = lowTicks_q >= sent_slot_pkg::SHORT_SYNC_MIN
        && lowTicks_q <= sent_slot_pkg::SHORT_SYNC_MAX;
    wire inLongOut = lowTicks_q >= sent_slot_pkg::LONG_OUT_MIN
        && lowTicks_q <= sent_slot_pkg::LONG_OUT_MAX;
    wire inLongSync = lowTicks_q >= sent_slot_pkg::LONG_SYNC_MIN
        && lowTicks_q <= sent_slot_pkg::LONG_SYNC_MAX;
    wire isOutput = decodeEn & ((shortWin & inShortOut) | (modeLong & inLongOut)); // R14 R15 R18
    wire isSample = decodeEn & shortWin & inShortSmp; // R14 R18
    wire isSync = decodeEn & ((modeShort & inShortSync) | (modeLong & inLongSync)); // R13 R15
    wire isInc = decodeEn & modeId & (state_q == ST_ADDR)
        & (lowTicks_q < sent_slot_pkg::SHORT_OUT_MIN); // R16
    wire addrEvt = isOutput | (isSample & holdPulseAddresses); // R12
    wire zeroHold = seqMode & isOutput & zeroSample & (slotCnt_q == 2'h0); // R10
    wire sampleNow = (isSample & ~noSample) | zeroHold; // R11 R19

    wire [1:0] slotNext = (slotCnt_q == maxSens) ? 2'h0 : slotCnt_q + 2'h1; // R22

    // Slot mark decode from the high gap before the responder's sync pulse
    wire [1:0] measId = (highTicks_q < sent_slot_pkg::MARK_LIM0) ? 2'h0 :
        (highTicks_q < sent_slot_pkg::MARK_LIM1) ? 2'h1 :
        (highTicks_q < sent_slot_pkg::MARK_LIM2) ? 2'h2 : 2'h3;
    wire measDone = measPend_q & lineFall & (highTicks_q <= sent_slot_pkg::MARK_TIMEOUT);
    wire [1:0] measNext = (measId == maxSens) ? 2'h0 : measId + 2'h1;

    // Response delay: slot mark or minimum high, stretched for short ticks
    wire [9:0] delayTicks = (seqMode & slotMark) ? sent_slot_pkg::markTicks(sensorId)
        : sent_slot_pkg::MIN_HIGH_TICKS; // R23 R07
    wire [19:0] markCyc = 20'(delayTicks * TICK_CYCLES);
    wire [19:0] syncCyc = 20'(sent_slot_pkg::SYNC_PULSE_TICKS * TICK_CYCLES);
    wire [19:0] floorCyc = (sent_slot_pkg::MIN_RESP_CYC > syncCyc)
        ? sent_slot_pkg::MIN_RESP_CYC - syncCyc : 20'h00000; // R08
    wire [19:0] respCyc = (markCyc > floorCyc) ? markCyc : floorCyc;
    wire waitDone = waitCnt_q >= respCyc - 20'h00001;

    wire [31:0] statusWord = {27'h0000000, contention_q, heldValid_q, online_q, slotCnt_q};
    wire [31:0] rdMux = (cfgAddr == sent_slot_pkg::CFG_OFFSET) ? cfg_q :
        (cfgAddr == sent_slot_pkg::STATUS_OFFSET) ? statusWord : 32'h00000000;

    // Pin synchroniser; line idles high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lineMeta_q <= 1'b1;
            lineSync_q <= 1'b1;
            linePrev_q <= 1'b1;
        end else if (clkEn) begin
            lineMeta_q <= lineIn;
            lineSync_q <= lineMeta_q;
            linePrev_q <= lineSync_q;
        end
    end

    // Tick divider and saturating low/high tick counters
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tickDiv_q <= 16'h0000;
            lowTicks_q <= 10'h000;
            highTicks_q <= 10'h000;
        end else if (clkEn) begin
            tickDiv_q <= tick ? 16'h0000 : tickDiv_q + 16'h0001;
            if (lineFall) begin
                lowTicks_q <= 10'h000;
            end else if (tick && !lineSync_q && lowTicks_q != sent_slot_pkg::TICK_SAT) begin
                lowTicks_q <= lowTicks_q + 10'h001;
            end
            if (lineRise) begin
                highTicks_q <= 10'h000;
            end else if (tick && lineSync_q && highTicks_q != sent_slot_pkg::TICK_SAT) begin
                highTicks_q <= highTicks_q + 10'h001;
            end
        end
    end

    // Configuration register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
            cfgRdata_q <= 32'h00000000;
        end else if (clkEn) begin
            if (cfgWe && cfgAddr == sent_slot_pkg::CFG_OFFSET) begin
                cfg_q <= cfgWdata;
            end
            cfgRdata_q <= rdMux;
        end
    end

    always_comb begin
        state_d = state_q;
        slotCnt_d = slotCnt_q;
        incCnt_d = incCnt_q;
        expSlot_d = expSlot_q;
        online_d = online_q;
        contention_d = contention_q;
        heldValid_d = heldValid_q;
        measPend_d = measPend_q;
        skip_d = skip_q;
        waitCnt_d = waitCnt_q;
        frameStart_d = 1'b0;
        frameUseHeld_d = frameUseHeld_q;
        sampleHold_d = 1'b0;
        // Configuration applies at the first enabled edge after reset
        if (pwrUp_q && !porOffline) begin
            online_d = 1'b1; // R05 R04
            slotCnt_d = 2'h0; // R05
        end
        if (lineRise) begin
            skip_d = 1'b0;
        end else if (highLong) begin
            // Nobody answered: stop waiting for a frame
            skip_d = 1'b0;
            measPend_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (lineSync_q && highTicks_q >= sent_slot_pkg::ID_END_TICKS) begin
                    skip_d = 1'b1;
                    state_d = ST_IDLE;
                    if (online_q && incCnt_q == sensorId) begin // R17 R25
                        state_d = ST_WAIT;
                        waitCnt_d = 20'h00000;
                    end
                end
            end
            ST_WAIT: begin
                if (lineFall) begin
                    // Someone else drove the line; never start on a busy bus
                    state_d = ST_IDLE;
                end else if (waitDone) begin
                    frameStart_d = 1'b1; // R07 R08
                    frameUseHeld_d = heldValid_q; // R09
                    heldValid_d = 1'b0;
                    state_d = ST_IDLE;
                end else begin
                    waitCnt_d = waitCnt_q + 20'h00001;
                end
            end
        endcase
        if (sampleNow) begin
            sampleHold_d = 1'b1; // R10 R12
            heldValid_d = 1'b1;
        end
        if (isSync) begin
            slotCnt_d = 2'h0; // R13
            online_d = 1'b1; // R04
            contention_d = 1'b0;
            measPend_d = 1'b0;
            state_d = ST_IDLE;
        end else if (addrEvt && seqMode) begin
            slotCnt_d = slotNext; // R21
            skip_d = 1'b1;
            measPend_d = slotMark; // R24
            expSlot_d = slotCnt_q;
            if (online_q && slotCnt_q == sensorId) begin // R21 R25
                state_d = ST_WAIT;
                waitCnt_d = 20'h00000;
            end
        end else if (addrEvt && modeId) begin
            state_d = ST_ADDR;
            incCnt_d = 2'h0;
        end else if (isInc && incCnt_q != 2'h3) begin
            incCnt_d = incCnt_q + 2'h1; // R17
        end
        if (idleEvt && idleSync) begin
            slotCnt_d = 2'h0; // R03
            online_d = 1'b1; // R04
            contention_d = 1'b0;
        end
        if (measDone) begin
            measPend_d = 1'b0;
            if (online_q && measId != expSlot_q) begin
                online_d = 1'b0; // R24
                contention_d = 1'b1;
            end else if (!online_q && !contention_q && slotSync && slotMark) begin
                slotCnt_d = measNext; // R01
                online_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            slotCnt_q <= 2'h0;
            incCnt_q <= 2'h0;
            expSlot_q <= 2'h0;
            online_q <= 1'b0;
            contention_q <= 1'b0;
            heldValid_q <= 1'b0;
            pwrUp_q <= 1'b1;
            measPend_q <= 1'b0;
            skip_q <= 1'b0;
            waitCnt_q <= 20'h00000;
        end else if (clkEn) begin
            state_q <= state_d;
            slotCnt_q <= slotCnt_d;
            incCnt_q <= incCnt_d;
            expSlot_q <= expSlot_d;
            online_q <= online_d;
            contention_q <= contention_d;
            heldValid_q <= heldValid_d;
            pwrUp_q <= 1'b0;
            measPend_q <= measPend_d;
            skip_q <= skip_d;
            waitCnt_q <= waitCnt_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frameStart_q <= 1'b0;
            frameUseHeld_q <= 1'b0;
            sampleHold_q <= 1'b0;
        end else if (clkEn) begin
            frameStart_q <= frameStart_d;
            frameUseHeld_q <= frameUseHeld_d;
            sampleHold_q <= sampleHold_d;
        end else begin
            frameStart_q <= 1'b0;
            sampleHold_q <= 1'b0;
        end
    end

    assign cfgRdata = cfgRdata_q;
    assign frameStart = frameStart_q;
    assign frameUseHeld = frameUseHeld_q;
    assign sampleHold = sampleHold_q;
    assign online = online_q;

    property p_idle_clear;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && idleEvt && idleSync && !measDone) |=> (slotCnt_q == 2'h0) && online_q;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle sync missed"); // R03

    property p_sync_slot0;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && isSync) |=> (slotCnt_q == 2'h0) && online_q && !contention_q;
    endproperty
    a_sync_slot0: assert property (p_sync_slot0) else $error("sync did not reset slot"); // R13

    property p_offline_silent;
        @(posedge sys_clk) disable iff (rst)
        frameStart_q |-> $past(online_q);
    endproperty
    a_offline_silent: assert property (p_offline_silent) else $error("offline frame"); // R25

    property p_min_high;
        @(posedge sys_clk) disable iff (rst)
        frameStart_q |-> lineSync_q && highTicks_q >= sent_slot_pkg::MIN_HIGH_TICKS;
    endproperty
    a_min_high: assert property (p_min_high) else $error("response too early"); // R07

    property p_floor_wait;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && state_q == ST_WAIT && waitDone && !lineFall)
            |-> waitCnt_q + 20'h00001 >= floorCyc;
    endproperty
    a_floor_wait: assert property (p_floor_wait) else $error("70.4 us floor broken"); // R08

    property p_seq_nohold;
        @(posedge sys_clk) disable iff (rst)
        sampleHold_q |-> !$past(seqMode && noSample && !zeroSample);
    endproperty
    a_seq_nohold: assert property (p_seq_nohold) else $error("held with no-sample"); // R11

    property p_id_nohold;
        @(posedge sys_clk) disable iff (rst)
        sampleHold_q |-> !$past(modeId && noSample);
    endproperty
    a_id_nohold: assert property (p_id_nohold) else $error("id scheme held sample"); // R19

    property p_zero_hold;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && zeroHold) |=> sampleHold_q ##1 !sampleHold_q;
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("slot 0 hold missing"); // R10

    property p_wrap;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && addrEvt && seqMode && !isSync && !idleEvt && slotCnt_q == maxSens
            && !(pwrUp_q && !porOffline)) |=> slotCnt_q == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("slot counter failed to wrap"); // R22

    property p_powerup;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && pwrUp_q && !porOffline && !measDone) |=> online_q && slotCnt_q == 2'h0;
    endproperty
    a_powerup: assert property (p_powerup) else $error("not online after reset"); // R05

    property p_mismatch;
        @(posedge sys_clk) disable iff (rst)
        (clkEn && measDone && online_q && measId != expSlot_q) |=> !online_q && contention_q;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch kept online"); // R24
endmodule : sent_slot_addressing

//--- test/sent_host_model.sv
`timescale 1ns/1ps
module sent_host_model #(
    parameter int TICK = 4
) (
    // Clock
    input wire logic sys_clk,
    // Shared line, pulled high when nobody drives it
    output logic lineIn
);
    initial lineIn = 1'b1;

    // Caller enters just after a rising edge
    task automatic lowPulse(input int ticks);
        lineIn = 1'b0;
        repeat (ticks * TICK) @(posedge sys_clk);
        #1 lineIn = 1'b1;
    endtask : lowPulse

    task automatic highGap(input int ticks);
        repeat (ticks * TICK) @(posedge sys_clk);
        #1;
    endtask : highGap

    // Short id pulses stay well under the 18-tick end of sequence
    task automatic idPoll(input int fnTicks, input int count);
        lowPulse(fnTicks);
        repeat (count) begin
            highGap(6);
            lowPulse(4);
        end
    endtask : idPoll
endmodule : sent_host_model

//--- test/sent_slot_addressing_bench.sv
`timescale 1ns/1ps
module sent_slot_addressing_bench;
    localparam int TICK = 4;
    // Frame sync pulse is 56 ticks, so the 70.4 us floor leaves this many cycles of high
    localparam int RESP_MIN = int'(sent_slot_pkg::MIN_RESP_CYC) - 56 * TICK;
    localparam logic [7:0] CFG = sent_slot_pkg::CFG_OFFSET;
    localparam logic [7:0] STAT = sent_slot_pkg::STATUS_OFFSET;
    logic sys_clk, rst, clkEn, lineIn, cfgWe;
    logic [1:0] sensorId;
    logic [2:0] transmitSchemeSelect;
    logic [7:0] cfgAddr;
    logic [31:0] cfgWdata, cfgRdata;
    logic frameStart, frameUseHeld, sampleHold, online;
    int mismatches, checkCount, holdCount, frameCount;

    sent_slot_addressing #(
        .TICK_CYCLES(16'(TICK))
    ) i_sent_slot_addressing (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .lineIn(lineIn),
        .sensorId(sensorId),
        .transmitSchemeSelect(transmitSchemeSelect),
        .cfgWe(cfgWe),
        .cfgAddr(cfgAddr),
        .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata),
        .frameStart(frameStart),
        .frameUseHeld(frameUseHeld),
        .sampleHold(sampleHold),
        .online(online)
    );

    sent_host_model #(.TICK(TICK)) i_sent_host_model (.sys_clk(sys_clk), .lineIn(lineIn));

    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (sampleHold === 1'b1) holdCount <= holdCount + 1;
        if (frameStart === 1'b1) frameCount <= frameCount + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic cfgWrite(input logic [7:0] addr, input logic [31:0] data);
        cfgAddr = addr;
        cfgWdata = data;
        cfgWe = 1'b1;
        @(posedge sys_clk);
        #1 cfgWe = 1'b0;
    endtask : cfgWrite

    task automatic readCheck(input logic [7:0] addr, input logic [31:0] exp, input string what);
        cfgAddr = addr;
        @(posedge sys_clk);
        #1 check(cfgRdata, exp, what);
    endtask : readCheck

    task automatic pg(input int low, input int high);
        i_sent_host_model.lowPulse(low);
        i_sent_host_model.highGap(high);
    endtask : pg

    // Bounded wait from the host's release; delay and held flag checked at the pulse
    task automatic expectFrame(input int minCyc, input int maxCyc, input logic held);
        int n;
        n = 0;
        while (frameStart !== 1'b1 && n < maxCyc) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(32'(frameStart), 32'h1, "frame start");
        check(32'(n >= minCyc), 32'h1, "response delay");
        check(32'(frameUseHeld), 32'(held), "held select");
    endtask : expectFrame

    task automatic completeRun();
        $display("Checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : completeRun

    initial begin
        repeat (90000) @(posedge sys_clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        completeRun();
    end

    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        cfgWe = 1'b0;
        cfgAddr = 8'h00;
        cfgWdata = 32'h0000_0000;
        sensorId = 2'h1;
        transmitSchemeSelect = sent_slot_pkg::SCHEME_SHORT;
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        readCheck(STAT, 32'h0000_0004, "power-up status");
        readCheck(CFG, 32'h0000_0000, "config reset");
        readCheck(8'h30, 32'h0000_0000, "unmapped read");
        // A write while the enable is low must leave no trace
        clkEn = 1'b0;
        cfgWrite(CFG, 32'h0203_0000);
        clkEn = 1'b1;
        readCheck(CFG, 32'h0000_0000, "frozen write");
        cfgWrite(STAT, 32'h0000_00FF);
        readCheck(STAT, 32'h0000_0004, "status read-only");
        cfgWrite(CFG, 32'h0203_0000);
        readCheck(CFG, 32'h0203_0000, "config readback");
        pg(17, 100);
        check(32'(holdCount), 32'h1, "zero-slot hold");
        readCheck(STAT, 32'h0000_000D, "slot step");
        i_sent_host_model.lowPulse(17);
        expectFrame(RESP_MIN, RESP_MIN + 16, 1'b1);
        i_sent_host_model.highGap(100);
        pg(104, 100);
        readCheck(STAT, 32'h0000_0004, "slot after sync");
        // No-sample, sample pulse as broadcast
        cfgWrite(CFG, 32'h000B_0000);
        pg(35, 100);
        check(32'(holdCount), 32'h1, "no-sample hold");
        readCheck(STAT, 32'h0000_0004, "broadcast no step");
        pg(17, 100);
        i_sent_host_model.lowPulse(17);
        expectFrame(RESP_MIN, RESP_MIN + 16, 1'b0);
        i_sent_host_model.highGap(100);
        pg(17, 100);
        pg(17, 100);
        readCheck(STAT, 32'h0000_0004, "slot wrap");
        cfgWrite(CFG, 32'h0023_0000);
        pg(17, 100);
        readCheck(STAT, 32'h0000_0005, "slot before idle");
        i_sent_host_model.highGap(420);
        readCheck(STAT, 32'h0000_0004, "idle sync");
        transmitSchemeSelect = sent_slot_pkg::SCHEME_LONG;
        cfgWrite(CFG, 32'h0003_0000);
        pg(81, 100);
        readCheck(STAT, 32'h0000_0005, "long output");
        pg(106, 100);
        readCheck(STAT, 32'h0000_0004, "long sync");
        // Id-polled scheme with sample pulses addressing
        transmitSchemeSelect = sent_slot_pkg::SCHEME_ID;
        cfgWrite(CFG, 32'h0013_0000);
        i_sent_host_model.idPoll(35, 1);
        expectFrame(RESP_MIN, RESP_MIN + 18 * TICK + 24, 1'b1);
        check(32'(holdCount), 32'h2, "id sample hold");
        i_sent_host_model.highGap(100);
        i_sent_host_model.idPoll(17, 2);
        i_sent_host_model.highGap(2200);
        i_sent_host_model.idPoll(17, 1);
        expectFrame(RESP_MIN, RESP_MIN + 18 * TICK + 24, 1'b0);
        i_sent_host_model.highGap(10);
        check(32'(frameCount), 32'h4, "frame total");
        check(32'(online), 32'h1, "online");
        completeRun();
    end
endmodule : sent_slot_addressing_bench
